// ### hw/sysclk_cfg.sv
// APB register block for run-mode clock configuration, divider choice and peripheral clock gating.
// Assumes a single ref_clk domain and sleep requests from the core on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sysclk_regs.svh"
module sysclk_cfg
	import sysclk_pkg::*;
#(
	parameter int N = 32
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        sleep_req,
	input  wire logic        deep_sleep_req,
	output var  logic [N-1:0] periph_clk_en,
	output var  logic        sys_div_en,
	output var  logic [3:0]  sys_divisor,
	output var  logic        pll_selected
);
	typedef enum logic [5:0] {
		SEL_NONE   = 6'b000000,
		SEL_CFG1   = 6'b000001,
		SEL_CFG2   = 6'b000010,
		SEL_RUN    = 6'b000100,
		SEL_SLEEP  = 6'b001000,
		SEL_DEEP   = 6'b010000,
		SEL_STATUS = 6'b100000
	} reg_sel_t;

	typedef struct packed {
		logic [31:0]  run_cfg;
		logic [31:0]  second_cfg;
		logic [N-1:0] run_gate;
		logic [N-1:0] sleep_gate;
		logic [N-1:0] deep_gate;
		logic [31:0]  rdata;
		logic         err;
		logic         div_en;
		logic [3:0]   divisor;
		logic         pll_sel;
	} cfg_state_t;

	cfg_state_t st_reg;
	cfg_state_t st_next;

	gate_if #(.N(N)) gif ();

	function automatic reg_sel_t decode(input logic [11:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		unique case (a)
			`RUN_CFG_OFS:    s = SEL_CFG1;
			`SECOND_CFG_OFS: s = SEL_CFG2;
			`RUN_GATE_OFS:   s = SEL_RUN;
			`SLEEP_GATE_OFS: s = SEL_SLEEP;
			`DEEP_GATE_OFS:  s = SEL_DEEP;
			`CLK_STATUS_OFS: s = SEL_STATUS;
			default:         s = SEL_NONE;
		endcase
		return s;
	endfunction : decode

	reg_sel_t     sel;
	logic         setup_ph;
	logic         wr_acc;
	logic [31:0]  status_word;
	logic [31:0]  run_w;
	logic [31:0]  sleep_w;
	logic [31:0]  deep_w;

	assign sel      = decode(paddr);
	assign setup_ph = psel && !penable;
	assign wr_acc   = psel && penable && pwrite;
	assign run_w    = 32'(st_reg.run_gate);
	assign sleep_w  = 32'(st_reg.sleep_gate);
	assign deep_w   = 32'(st_reg.deep_gate);
	assign status_word = {23'h000000, st_reg.pll_sel, st_reg.divisor, st_reg.div_en, gif.mode};

	always_comb begin
		st_next = st_reg;
		// Read data and error are captured in the setup cycle so they come from flops in the access cycle
		if (setup_ph) begin
			st_next.err = (sel == SEL_NONE) || (pwrite && sel == SEL_STATUS);
			unique case (sel)
				SEL_CFG1:   st_next.rdata = st_reg.run_cfg;
				SEL_CFG2:   st_next.rdata = st_reg.second_cfg;
				SEL_RUN:    st_next.rdata = run_w;
				SEL_SLEEP:  st_next.rdata = sleep_w;
				SEL_DEEP:   st_next.rdata = deep_w;
				SEL_STATUS: st_next.rdata = status_word;
				default:    st_next.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc) begin
			unique case (sel)
				SEL_CFG1:  st_next.run_cfg    = pwdata & `RUN_CFG_WMASK;
				SEL_CFG2:  st_next.second_cfg = pwdata & `SECOND_CFG_WMASK;
				SEL_RUN:   st_next.run_gate   = pwdata[N-1:0];
				SEL_SLEEP: st_next.sleep_gate = pwdata[N-1:0];
				SEL_DEEP:  st_next.deep_gate  = pwdata[N-1:0];
				default:   st_next.err = st_reg.err;
			endcase
		end
		// PLL is the source unless bypassed
		st_next.pll_sel = !st_reg.run_cfg[`BYPASS_BIT];
		// The PLL forces the divider whatever the divider-use bit holds
		st_next.div_en  = st_reg.run_cfg[`DIV_USE_BIT] || !st_reg.run_cfg[`BYPASS_BIT];
		// Override bit picks the second register's divisor field
		if (st_reg.second_cfg[`OVERRIDE_BIT])
			st_next.divisor = st_reg.second_cfg[`OVR_DIV_MSB:`OVR_DIV_LSB];
		else
			st_next.divisor = st_reg.run_cfg[`DIVISOR_MSB:`DIVISOR_LSB];
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg.run_cfg    <= `RUN_CFG_RESET;
			st_reg.second_cfg <= `SECOND_CFG_RESET;
			st_reg.run_gate   <= N'(`GATE_RESET);
			st_reg.sleep_gate <= N'(`GATE_RESET);
			st_reg.deep_gate  <= N'(`GATE_RESET);
			st_reg.rdata      <= 32'h0000_0000;
			st_reg.err        <= 1'b0;
			st_reg.div_en     <= 1'b0;
			st_reg.divisor    <= `DIVISOR_RESET;
			st_reg.pll_sel    <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign gif.auto_gate  = st_reg.run_cfg[`AUTO_GATE_BIT];
	assign gif.sleep_req  = sleep_req;
	assign gif.deep_req   = deep_sleep_req;
	assign gif.run_gate   = st_reg.run_gate;
	assign gif.sleep_gate = st_reg.sleep_gate;
	assign gif.deep_gate  = st_reg.deep_gate;

	gate_select #(.N(N)) u_gate_select (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.gif     (gif.sel)
	);

	assign prdata        = st_reg.rdata;
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && st_reg.err;
	assign periph_clk_en = gif.clk_en;
	assign sys_div_en    = st_reg.div_en;
	assign sys_divisor   = st_reg.divisor;
	assign pll_selected  = st_reg.pll_sel;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// Divider choice follows the stored configuration one edge later
	a_pll_forces_div: assert property (!st_reg.run_cfg[`BYPASS_BIT] |=> sys_div_en && pll_selected)
		else $error("divider not forced while PLL selected");
	a_div_follows_bit: assert property (st_reg.run_cfg[`BYPASS_BIT] |=>
		sys_div_en == $past(st_reg.run_cfg[`DIV_USE_BIT]))
		else $error("divider use does not follow its bit when bypassed");
	a_override_divisor: assert property (st_reg.second_cfg[`OVERRIDE_BIT] |=>
		sys_divisor == $past(st_reg.second_cfg[`OVR_DIV_MSB:`OVR_DIV_LSB]))
		else $error("override divisor not applied");
	a_own_divisor: assert property (!st_reg.second_cfg[`OVERRIDE_BIT] |=>
		sys_divisor == $past(st_reg.run_cfg[`DIVISOR_MSB:`DIVISOR_LSB]))
		else $error("own divisor field not applied without override");
	a_plain_divisor: assert property ((wr_acc && sel == SEL_CFG1 && !st_reg.second_cfg[`OVERRIDE_BIT]) |=> ##1
		sys_divisor == $past(pwdata[`DIVISOR_MSB:`DIVISOR_LSB], 2))
		else $error("written divisor field not applied");
	a_auto_write_path: assert property ((wr_acc && sel == SEL_CFG1) |=>
		gif.auto_gate == $past(pwdata[`AUTO_GATE_BIT]))
		else $error("auto gating bit not stored");

	// Register bus behaviour
	a_cfg_mask_kept: assert property ((wr_acc && sel == SEL_CFG1) |=>
		(st_reg.run_cfg & ~(`RUN_CFG_WMASK)) == 32'h0000_0000)
		else $error("read-only bits of run configuration changed");
	a_cfg2_mask_kept: assert property ((wr_acc && sel == SEL_CFG2) |=>
		(st_reg.second_cfg & ~(`SECOND_CFG_WMASK)) == 32'h0000_0000)
		else $error("read-only bits of second configuration changed");
	a_bad_addr_err: assert property ((setup_ph && sel == SEL_NONE) |=> (!penable || pslverr))
		else $error("unmapped access not refused");
	a_status_wr_ignored: assert property ((wr_acc && sel == SEL_STATUS) |=>
		($stable(st_reg.run_cfg) && $stable(st_reg.second_cfg)))
		else $error("status write changed configuration");
	a_cfg_readback: assert property ((setup_ph && !pwrite && sel == SEL_CFG1) |=>
		prdata == $past(st_reg.run_cfg))
		else $error("run configuration read data wrong");
	a_good_addr_ok: assert property ((setup_ph && !pwrite && sel != SEL_NONE) |=> !pslverr)
		else $error("error raised on a mapped read");

	c_pll_forced: cover property (!st_reg.run_cfg[`BYPASS_BIT] && !st_reg.run_cfg[`DIV_USE_BIT] && sys_div_en);
	c_override_used: cover property (st_reg.second_cfg[`OVERRIDE_BIT] &&
		sys_divisor != st_reg.run_cfg[`DIVISOR_MSB:`DIVISOR_LSB]);
	c_bad_addr: cover property (pslverr);
endmodule : sysclk_cfg
`default_nettype wire

// ### inc/sysclk_regs.svh
// Register offsets, field positions, reset values and masks for the clock configuration block.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef SYSCLK_REGS_SVH
`define SYSCLK_REGS_SVH

`define RUN_CFG_OFS        12'h060
`define SECOND_CFG_OFS     12'h070
`define RUN_GATE_OFS       12'h100
`define SLEEP_GATE_OFS     12'h110
`define DEEP_GATE_OFS      12'h120
`define CLK_STATUS_OFS     12'h130

`define RUN_CFG_RESET      32'h078E_3AC0
`define RUN_CFG_WMASK      32'h0FDE_3FFF
`define SECOND_CFG_RESET   32'h0780_0000
`define SECOND_CFG_WMASK   32'h8780_0000
`define GATE_RESET         32'hFFFF_FFFF

`define DIVISOR_RESET      4'hF
`define AUTO_GATE_BIT      27
`define DIVISOR_LSB        23
`define DIVISOR_MSB        26
`define DIV_USE_BIT        22
`define BYPASS_BIT         11
`define OVERRIDE_BIT       31
`define OVR_DIV_LSB        23
`define OVR_DIV_MSB        26

`endif

// ### inc/sysclk_pkg.sv
// Types shared by the clock configuration block and its gating selector.
// Assumes nothing beyond a SystemVerilog compiler.
package sysclk_pkg;
	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_DEEP  = 3'b100
	} pwr_mode_t;
endpackage : sysclk_pkg

// ### inc/gate_if.sv
// Signals between the register block and the peripheral clock gating selector.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface gate_if #(parameter int N = 32);
	import sysclk_pkg::*;
	logic             auto_gate;
	logic             sleep_req;
	logic             deep_req;
	logic [N-1:0]     run_gate;
	logic [N-1:0]     sleep_gate;
	logic [N-1:0]     deep_gate;
	logic [N-1:0]     clk_en;
	pwr_mode_t        mode;
	modport cfg (output auto_gate, sleep_req, deep_req, run_gate, sleep_gate, deep_gate, input clk_en, mode);
	modport sel (input auto_gate, sleep_req, deep_req, run_gate, sleep_gate, deep_gate, output clk_en, mode);
endinterface : gate_if
`default_nettype wire

// ### hw/gate_select.sv
// Power-mode tracker and peripheral clock enable selector.
// Assumes sleep and deep-sleep requests come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module gate_select
	import sysclk_pkg::*;
#(
	parameter int N = 32
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	gate_if.sel       gif
);
	typedef struct packed {
		pwr_mode_t    mode;
		logic [N-1:0] clk_en;
	} sel_state_t;

	sel_state_t st_reg;
	sel_state_t st_next;

	function automatic logic [N-1:0] pick_gate(input pwr_mode_t m, input logic ag,
		input logic [N-1:0] rg, input logic [N-1:0] sg, input logic [N-1:0] dg);
		logic [N-1:0] r;
		r = rg;
		unique case (m)
			MODE_RUN:   r = rg;
			MODE_SLEEP: r = ag ? sg : rg;
			MODE_DEEP:  r = ag ? dg : rg;
			default:    r = rg;
		endcase
		return r;
	endfunction : pick_gate

	always_comb begin
		st_next = st_reg;
		if (gif.deep_req)
			st_next.mode = MODE_DEEP;
		else if (gif.sleep_req)
			st_next.mode = MODE_SLEEP;
		else
			st_next.mode = MODE_RUN;
		st_next.clk_en = pick_gate(st_reg.mode, gif.auto_gate, gif.run_gate, gif.sleep_gate, gif.deep_gate);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg.mode   <= MODE_RUN;
			st_reg.clk_en <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign gif.clk_en = st_reg.clk_en;
	assign gif.mode   = st_reg.mode;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_run_mode_gate: assert property ((st_reg.mode == MODE_RUN) |=> st_reg.clk_en == $past(gif.run_gate))
		else $error("run mode enables not from run gating word");
	a_auto_sleep_gate: assert property ((gif.auto_gate && st_reg.mode != MODE_RUN) |=>
		st_reg.clk_en == ($past(st_reg.mode) == MODE_SLEEP ? $past(gif.sleep_gate) : $past(gif.deep_gate)))
		else $error("auto gating did not take sleep or deep-sleep word");
	a_manual_keep_run: assert property ((!gif.auto_gate && st_reg.mode != MODE_RUN) |=>
		st_reg.clk_en == $past(gif.run_gate))
		else $error("run gating word not kept in low-power mode");
	c_deep_auto: cover property (gif.auto_gate && st_reg.mode == MODE_DEEP);
	c_sleep_manual: cover property (!gif.auto_gate && st_reg.mode == MODE_SLEEP);
endmodule : gate_select
`default_nettype wire

// ### tb/sysclk_divider_gating_select_bench.sv
// Self-checking bench for the clock configuration block: APB registers, gating selection, divider outputs.
// Assumes sysclk_cfg with N=32, the offsets and masks of sysclk_regs.svh and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "sysclk_regs.svh"
module sysclk_divider_gating_select_bench;
	logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic        sleep_req, deep_sleep_req, sys_div_en, pll_selected, err;
	logic [11:0] paddr;
	logic [3:0]  sys_divisor;
	logic [31:0] pwdata, prdata, periph_clk_en, rd, rg, sg, dg, cfg_w, cfg2_w;
	int          n_fail, cmp_count;

	sysclk_cfg #(.N(32)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .periph_clk_en(periph_clk_en),
		.sys_div_en(sys_div_en), .sys_divisor(sys_divisor), .pll_selected(pll_selected)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the edge where pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && i < 50) begin
			@(posedge ref_clk);
			i++;
		end
		if (i >= 50)
			n_fail++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task gate_check(input logic ag, input logic sl, input logic dp);
		cfg_w = `RUN_CFG_RESET;
		cfg_w[`AUTO_GATE_BIT] = ag;
		apb(1'b1, `RUN_CFG_OFS, cfg_w);
		@(posedge ref_clk);
		sleep_req      <= sl;
		deep_sleep_req <= dp;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("periph_clk_en", (ag && dp) ? dg : (ag && sl) ? sg : rg, periph_clk_en);
	endtask : gate_check

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		summarize;
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sleep_req = 1'b0;
		deep_sleep_req = 1'b0;
		n_fail = 0;
		cmp_count = 0;
		void'($urandom(32'h549E));
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("sys_div_en", 32'h0, {31'h0, sys_div_en});
		chk("sys_divisor", 32'hF, {28'h0, sys_divisor});
		chk("periph_clk_en", `GATE_RESET, periph_clk_en);
		apb(1'b0, `RUN_CFG_OFS, 32'h0);
		chk("run_cfg", `RUN_CFG_RESET, rd);
		apb(1'b0, `SECOND_CFG_OFS, 32'h0);
		chk("second_cfg", `SECOND_CFG_RESET, rd);
		rg = $urandom;
		sg = $urandom;
		dg = $urandom;
		apb(1'b1, `RUN_GATE_OFS, rg);
		apb(1'b1, `SLEEP_GATE_OFS, sg);
		apb(1'b1, `DEEP_GATE_OFS, dg);
		apb(1'b0, `DEEP_GATE_OFS, 32'h0);
		chk("deep_gate", dg, rd);
		for (int k = 0; k < 8; k++)
			gate_check(k[2], k[1], k[0]);
		@(posedge ref_clk);
		sleep_req      <= 1'b0;
		deep_sleep_req <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			cfg_w = `RUN_CFG_RESET ^ ($urandom & `RUN_CFG_WMASK);
			cfg_w[`BYPASS_BIT] = k[0];
			cfg_w[`DIV_USE_BIT] = k[1];
			cfg2_w = $urandom & `SECOND_CFG_WMASK;
			cfg2_w[`OVERRIDE_BIT] = k[2];
			apb(1'b1, `RUN_CFG_OFS, cfg_w);
			apb(1'b1, `SECOND_CFG_OFS, cfg2_w);
			repeat (2) @(posedge ref_clk);
			#1;
			chk("sys_div_en", {31'h0, k[1] | ~k[0]}, {31'h0, sys_div_en});
			chk("pll_selected", {31'h0, ~k[0]}, {31'h0, pll_selected});
			chk("sys_divisor", {28'h0, k[2] ? cfg2_w[`OVR_DIV_MSB:`OVR_DIV_LSB] : cfg_w[`DIVISOR_MSB:`DIVISOR_LSB]},
				{28'h0, sys_divisor});
			apb(1'b0, `RUN_CFG_OFS, 32'h0);
			chk("run_cfg", cfg_w & `RUN_CFG_WMASK, rd);
		end
		apb(1'b0, `CLK_STATUS_OFS, 32'h0);
		chk("status", {23'h0, 1'b0, cfg2_w[`OVR_DIV_MSB:`OVR_DIV_LSB], 1'b1, 3'b001}, rd);
		apb(1'b0, 12'h0F0, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
		apb(1'b1, `CLK_STATUS_OFS, $urandom);
		chk("status_wr_err", 32'h1, {31'h0, err});
		// Second reset in mid-run restores the reset divider choice
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("sys_div_en", 32'h0, {31'h0, sys_div_en});
		chk("sys_divisor", 32'hF, {28'h0, sys_divisor});
		summarize;
	end
endmodule : sysclk_divider_gating_select_bench
`default_nettype wire
